// *** hw/csw_ctrl.sv ***
// chip-select area access sequencer with wait and hold timing, APB registers
// Notes on behaviour
// - codes 1001..1100 give 12,14,18,24 waits
// - wait mask bit 6: 0 honour, 1 ignore
// - mask applies even with zero wait count
// - bits 5..2 read zero, written zero
// - hold 0.5/1.5/2.5 cycles after strobe
module csw_ctrl
  import csw_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // apb slave
  input  wire logic [PADDR_W-1:0] paddr,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [PDATA_W-1:0] pwdata,
  output logic      [PDATA_W-1:0] prdata,
  output logic                    pready,
  output logic                    pslverr,
  // external bus
  output logic      [EXT_AW-1:0]  ext_addr,
  output logic      [EXT_DW-1:0]  ext_dout,
  output logic                    ext_dout_oe,
  input  wire logic [EXT_DW-1:0]  ext_din,
  output logic                    area_select_n,
  output logic                    rd_strobe_n,
  output logic      [LANES-1:0]   byte_lane_strobe_n,
  input  wire logic               ext_wait_n,
  // status
  output logic                    busy
);
  import csw_pkg::*;

  typedef enum logic [2:0] {
    CSW_R_TIMING, CSW_R_ADDR, CSW_R_WDATA, CSW_R_CMD, CSW_R_STATUS, CSW_R_RDATA, CSW_R_NONE
  } csw_reg_t;

  function automatic csw_reg_t csw_decode(input logic [PADDR_W-1:0] a);
    case (a)
      OFF_TIMING: csw_decode = CSW_R_TIMING;
      OFF_ADDR:   csw_decode = CSW_R_ADDR;
      OFF_WDATA:  csw_decode = CSW_R_WDATA;
      OFF_CMD:    csw_decode = CSW_R_CMD;
      OFF_STATUS: csw_decode = CSW_R_STATUS;
      OFF_RDATA:  csw_decode = CSW_R_RDATA;
      default:    csw_decode = CSW_R_NONE;
    endcase
  endfunction : csw_decode

  csw_wait_if wif ();

  csw_pin_sync u_sync (
    .clk        (clk),
    .rst_n      (rst_n),
    .ext_wait_n (ext_wait_n),
    .ext_din    (ext_din),
    .wif        (wif)
  );

  // configuration and data registers
  logic [3:0]         wait_code_reg, wait_code_next;
  logic               mask_reg,      mask_next;
  logic [1:0]         hold_code_reg, hold_code_next;
  logic [EXT_AW-1:0]  addr_reg,      addr_next;
  logic [EXT_DW-1:0]  wdata_reg,     wdata_next;
  logic [EXT_DW-1:0]  rdata_reg,     rdata_next;
  logic               done_reg,      done_next;
  // apb answer registers
  logic               pready_reg,    pready_next;
  logic               pslverr_reg,   pslverr_next;
  logic [PDATA_W-1:0] prdata_reg,    prdata_next;
  // sequencer registers
  csw_state_t         state_reg,     state_next;
  logic               dir_wr_reg,    dir_wr_next;
  logic [WCNT_W-1:0]  wcnt_reg,      wcnt_next;
  logic [1:0]         hcnt_reg,      hcnt_next;
  logic               sel_on_reg,    sel_on_next;
  logic               rd_stb_n_reg,  rd_stb_n_next;
  logic [LANES-1:0]   wr_stb_n_reg,  wr_stb_n_next;
  logic               oe_reg,        oe_next;
  logic               area_sel_n_reg;

  csw_reg_t           sel_reg_id;
  logic               acc_phase;
  logic               wr_take;
  logic               start_req;
  logic               done_set;
  logic               done_clr;
  logic [PDATA_W-1:0] rd_mux;

  assign wif.ext_wait_mask = mask_reg;
  assign sel_reg_id        = csw_decode(paddr);
  assign acc_phase         = psel & penable;
  // writes land on the edge that samples pready high
  assign wr_take           = acc_phase & pready_reg & pwrite;
  assign start_req         = wr_take & (sel_reg_id == CSW_R_CMD) & pwdata[CMD_START_BIT];
  assign done_clr          = wr_take & (sel_reg_id == CSW_R_STATUS) & pwdata[STAT_DONE_BIT];

  // read data multiplexer
  always_comb begin
    rd_mux = PRDATA_RST;
    case (sel_reg_id)
      CSW_R_TIMING: begin
        rd_mux[TIM_WAIT_MSB:TIM_WAIT_LSB] = wait_code_reg;
        rd_mux[TIM_MASK_BIT]              = mask_reg;
        rd_mux[TIM_RSV_MSB:TIM_RSV_LSB]   = 4'h0;
        rd_mux[TIM_HOLD_MSB:TIM_HOLD_LSB] = hold_code_reg;
      end
      CSW_R_ADDR:   rd_mux[EXT_AW-1:0] = addr_reg;
      CSW_R_WDATA:  rd_mux[EXT_DW-1:0] = wdata_reg;
      CSW_R_CMD:    rd_mux[CMD_WRITE_BIT] = dir_wr_reg;
      CSW_R_STATUS: begin
        rd_mux[STAT_BUSY_BIT] = (state_reg != CSW_IDLE);
        rd_mux[STAT_DONE_BIT] = done_reg;
      end
      CSW_R_RDATA:  rd_mux[EXT_DW-1:0] = rdata_reg;
      default:      rd_mux = PRDATA_RST;
    endcase
  end

  // apb slave: one wait state, answer from registers
  always_comb begin
    pready_next  = acc_phase & ~pready_reg;
    pslverr_next = acc_phase & ~pready_reg & (sel_reg_id == CSW_R_NONE);
    prdata_next  = prdata_reg;
    if (acc_phase && !pready_reg && !pwrite) begin
      prdata_next = rd_mux;
    end
  end

  // configuration writes; the wait code is taken at setup, while mask and hold also act on an access already running
  always_comb begin
    wait_code_next = wait_code_reg;
    mask_next      = mask_reg;
    hold_code_next = hold_code_reg;
    addr_next      = addr_reg;
    wdata_next     = wdata_reg;
    if (wr_take) begin
      case (sel_reg_id)
        CSW_R_TIMING: begin
          // reserved codes are not trapped; they run as 24 waits
          wait_code_next = pwdata[TIM_WAIT_MSB:TIM_WAIT_LSB];
          mask_next      = pwdata[TIM_MASK_BIT];
          hold_code_next = pwdata[TIM_HOLD_MSB:TIM_HOLD_LSB];
        end
        CSW_R_ADDR:  addr_next  = pwdata[EXT_AW-1:0];
        CSW_R_WDATA: wdata_next = pwdata[EXT_DW-1:0];
        default: begin
        end
      endcase
    end
  end

  // access sequencer
  always_comb begin
    state_next    = state_reg;
    dir_wr_next   = dir_wr_reg;
    wcnt_next     = wcnt_reg;
    hcnt_next     = hcnt_reg;
    sel_on_next   = sel_on_reg;
    rd_stb_n_next = rd_stb_n_reg;
    wr_stb_n_next = wr_stb_n_reg;
    oe_next       = oe_reg;
    rdata_next    = rdata_reg;
    done_set      = 1'b0;
    case (state_reg)
      CSW_IDLE: begin
        // a start while busy is ignored, only idle accepts it
        if (start_req) begin
          state_next  = CSW_SETUP;
          dir_wr_next = pwdata[CMD_WRITE_BIT];
          sel_on_next = 1'b1;
          oe_next     = pwdata[CMD_WRITE_BIT];
        end
      end
      CSW_SETUP: begin
        state_next = CSW_STROBE;
        wcnt_next  = WAIT_TABLE[wait_code_reg];
        if (dir_wr_reg) begin
          wr_stb_n_next = {LANES{1'b0}};
        end else begin
          rd_stb_n_next = 1'b0;
        end
      end
      CSW_STROBE: begin
        if (wcnt_reg != WCNT_ZERO) begin
          wcnt_next = wcnt_reg - 5'h01;
        // wait checked even at zero count
        end else if (wif.wait_active) begin
          wcnt_next = WCNT_ZERO;
        end else begin
          rd_stb_n_next = 1'b1;
          wr_stb_n_next = {LANES{1'b1}};
          if (!dir_wr_reg) begin
            rdata_next = wif.rd_data;
          end
          if (hold_code_reg == HCNT_ZERO) begin
            sel_on_next = 1'b0;
            oe_next     = 1'b0;
            done_set    = 1'b1;
            state_next  = CSW_IDLE;
          end else begin
            // code 11 is undefined and runs as the longest hold
            hcnt_next  = ((hold_code_reg > HOLD_MAX) ? HOLD_MAX : hold_code_reg) - 2'h1;
            state_next = CSW_HOLD;
          end
        end
      end
      CSW_HOLD: begin
        if (hcnt_reg == HCNT_ZERO) begin
          sel_on_next = 1'b0;
          oe_next     = 1'b0;
          done_set    = 1'b1;
          state_next  = CSW_IDLE;
        end else begin
          hcnt_next = hcnt_reg - 2'h1;
        end
      end
      default: begin
        state_next    = CSW_IDLE;
        sel_on_next   = 1'b0;
        rd_stb_n_next = 1'b1;
        wr_stb_n_next = {LANES{1'b1}};
        oe_next       = 1'b0;
      end
    endcase
    // completion beats a clear in the same cycle
    done_next = done_set | (done_reg & ~done_clr);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_code_reg <= WAIT_CODE_RST;
      mask_reg      <= MASK_RST;
      hold_code_reg <= HOLD_CODE_RST;
      addr_reg      <= EXT_ADDR_RST;
      wdata_reg     <= EXT_DATA_RST;
      rdata_reg     <= EXT_DATA_RST;
      done_reg      <= 1'b0;
      pready_reg    <= 1'b0;
      pslverr_reg   <= 1'b0;
      prdata_reg    <= PRDATA_RST;
      state_reg     <= CSW_IDLE;
      dir_wr_reg    <= 1'b0;
      wcnt_reg      <= WCNT_ZERO;
      hcnt_reg      <= HCNT_ZERO;
      sel_on_reg    <= 1'b0;
      rd_stb_n_reg  <= 1'b1;
      wr_stb_n_reg  <= {LANES{1'b1}};
      oe_reg        <= 1'b0;
    end else begin
      wait_code_reg <= wait_code_next;
      mask_reg      <= mask_next;
      hold_code_reg <= hold_code_next;
      addr_reg      <= addr_next;
      wdata_reg     <= wdata_next;
      rdata_reg     <= rdata_next;
      done_reg      <= done_next;
      pready_reg    <= pready_next;
      pslverr_reg   <= pslverr_next;
      prdata_reg    <= prdata_next;
      state_reg     <= state_next;
      dir_wr_reg    <= dir_wr_next;
      wcnt_reg      <= wcnt_next;
      hcnt_reg      <= hcnt_next;
      sel_on_reg    <= sel_on_next;
      rd_stb_n_reg  <= rd_stb_n_next;
      wr_stb_n_reg  <= wr_stb_n_next;
      oe_reg        <= oe_next;
    end
  end

  // falling-edge stage adds the half cycle
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      area_sel_n_reg <= 1'b1;
    end else begin
      area_sel_n_reg <= ~sel_on_reg;
    end
  end

  assign prdata             = prdata_reg;
  assign pready             = pready_reg;
  assign pslverr            = pslverr_reg;
  // address and data stay on the pins after deselect; only the select marks validity
  assign ext_addr           = addr_reg;
  assign ext_dout           = wdata_reg;
  assign ext_dout_oe        = oe_reg;
  assign area_select_n      = area_sel_n_reg;
  assign rd_strobe_n        = rd_stb_n_reg;
  assign byte_lane_strobe_n = wr_stb_n_reg;
  assign busy               = sel_on_reg;

endmodule : csw_ctrl

// *** include/csw_pkg.sv ***
// constants, types and tables for the chip-select wait and timing block
package csw_pkg;

  // bus and pin widths
  localparam int PADDR_W = 8;
  localparam int PDATA_W = 32;
  localparam int EXT_AW  = 16;
  localparam int EXT_DW  = 16;
  localparam int LANES   = 2;

  // register byte offsets
  localparam logic [PADDR_W-1:0] OFF_TIMING = 8'h00;
  localparam logic [PADDR_W-1:0] OFF_ADDR   = 8'h04;
  localparam logic [PADDR_W-1:0] OFF_WDATA  = 8'h08;
  localparam logic [PADDR_W-1:0] OFF_CMD    = 8'h0C;
  localparam logic [PADDR_W-1:0] OFF_STATUS = 8'h10;
  localparam logic [PADDR_W-1:0] OFF_RDATA  = 8'h14;

  // timing register fields
  localparam int TIM_WAIT_LSB = 7;
  localparam int TIM_WAIT_MSB = 10;
  localparam int TIM_MASK_BIT = 6;
  localparam int TIM_RSV_LSB  = 2;
  localparam int TIM_RSV_MSB  = 5;
  localparam int TIM_HOLD_LSB = 0;
  localparam int TIM_HOLD_MSB = 1;

  // command and status fields
  localparam int CMD_START_BIT = 0;
  localparam int CMD_WRITE_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // values after reset
  localparam logic [3:0]        WAIT_CODE_RST = 4'h0;
  localparam logic              MASK_RST      = 1'b0;
  localparam logic [1:0]        HOLD_CODE_RST = 2'h0;
  localparam logic [EXT_AW-1:0] EXT_ADDR_RST  = 16'h0000;
  localparam logic [EXT_DW-1:0] EXT_DATA_RST  = 16'h0000;
  localparam logic [PDATA_W-1:0] PRDATA_RST   = 32'h0000_0000;

  // wait cycles per access-wait code, index 15 first; reserved codes run as the longest
  localparam int WCNT_W = 5;
  localparam logic [15:0][WCNT_W-1:0] WAIT_TABLE = {
    5'h18, 5'h18, 5'h18, 5'h18, 5'h12, 5'h0E, 5'h0C, 5'h0A,
    5'h08, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
  localparam logic [WCNT_W-1:0] WCNT_ZERO = 5'h00;
  localparam logic [1:0]        HCNT_ZERO = 2'h0;
  localparam logic [1:0]        HOLD_MAX  = 2'h2;

  typedef enum logic [1:0] {
    CSW_IDLE   = 2'b00,
    CSW_SETUP  = 2'b01,
    CSW_STROBE = 2'b11,
    CSW_HOLD   = 2'b10
  } csw_state_t;

endpackage : csw_pkg

// *** include/csw_wait_if.sv ***
// carrier between the access sequencer and the pin synchroniser
interface csw_wait_if;
  import csw_pkg::*;
  logic              ext_wait_mask;
  logic              wait_active;
  logic [EXT_DW-1:0] rd_data;

  modport ctrl (output ext_wait_mask, input wait_active, input rd_data);
  modport sync (input ext_wait_mask, output wait_active, output rd_data);
endinterface : csw_wait_if

// *** hw/csw_pin_sync.sv ***
// two-stage synchronisers for the external wait and read data pins
module csw_pin_sync
  import csw_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // pins
  input  wire logic              ext_wait_n,
  input  wire logic [EXT_DW-1:0] ext_din,
  // sequencer side
  csw_wait_if.sync               wif
);
  import csw_pkg::*;

  logic              wait_s1_reg, wait_s2_reg;
  logic              wait_s1_next, wait_s2_next;
  logic [EXT_DW-1:0] din_s1_reg, din_s2_reg;
  logic [EXT_DW-1:0] din_s1_next, din_s2_next;

  always_comb begin
    wait_s1_next = ext_wait_n;
    wait_s2_next = wait_s1_reg;
    din_s1_next  = ext_din;
    din_s2_next  = din_s1_reg;
  end

  // idle level of the wait pin is high, so reset to released
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_s1_reg <= 1'b1;
      wait_s2_reg <= 1'b1;
      din_s1_reg  <= EXT_DATA_RST;
      din_s2_reg  <= EXT_DATA_RST;
    end else begin
      wait_s1_reg <= wait_s1_next;
      wait_s2_reg <= wait_s2_next;
      din_s1_reg  <= din_s1_next;
      din_s2_reg  <= din_s2_next;
    end
  end

  assign wif.wait_active = ~wait_s2_reg & ~wif.ext_wait_mask;
  assign wif.rd_data     = din_s2_reg;

endmodule : csw_pin_sync

// *** dv/csw_ctrl_chk.sv ***
// assertion checker for the chip-select wait and hold timing
module csw_ctrl_chk (
  // clock and reset
  input wire logic                        clk,
  input wire logic                        rst_n,
  // apb
  input wire logic [csw_pkg::PADDR_W-1:0] paddr,
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic                        pwrite,
  input wire logic [csw_pkg::PDATA_W-1:0] pwdata,
  input wire logic [csw_pkg::PDATA_W-1:0] prdata,
  input wire logic                        pready,
  // external bus
  input wire logic                        area_select_n,
  input wire logic                        rd_strobe_n,
  input wire logic [csw_pkg::LANES-1:0]   byte_lane_strobe_n,
  input wire logic                        ext_wait_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import csw_pkg::*;
  localparam int WT [16] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24, 24, 24, 24};
  logic       stb_n;
  logic       tim_wr;
  logic [3:0] wcode_reg, wcode_next;
  logic       msk_reg, msk_next;
  logic [1:0] hold_reg, hold_next;
  logic [5:0] lo_reg, lo_next;
  assign stb_n  = rd_strobe_n & (&byte_lane_strobe_n);
  assign tim_wr = psel & penable & pready & pwrite & (paddr == OFF_TIMING);
  // shadow of the timing fields, so checks follow what software set
  always_comb begin
    wcode_next = tim_wr ? pwdata[TIM_WAIT_MSB:TIM_WAIT_LSB] : wcode_reg;
    msk_next   = tim_wr ? pwdata[TIM_MASK_BIT] : msk_reg;
    hold_next  = tim_wr ? pwdata[TIM_HOLD_MSB:TIM_HOLD_LSB] : hold_reg;
    lo_next    = stb_n ? 6'h00 : lo_reg + 6'h01;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wcode_reg <= WAIT_CODE_RST;
      msk_reg   <= MASK_RST;
      hold_reg  <= HOLD_CODE_RST;
      lo_reg    <= 6'h00;
    end else begin
      wcode_reg <= wcode_next;
      msk_reg   <= msk_next;
      hold_reg  <= hold_next;
      lo_reg    <= lo_next;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  AST_LEN_EXACT: assert property ($rose(stb_n) && msk_reg |-> lo_reg == WT[wcode_reg] + 1)
    else $error("strobe length differs from wait code");
  AST_LEN_MIN: assert property ($rose(stb_n) |-> lo_reg >= WT[wcode_reg] + 1)
    else $error("strobe shorter than wait code");
  AST_WAIT_HOLD: assert property ((!ext_wait_n) [*3] ##0 (!stb_n && !msk_reg) |=> !stb_n)
    else $error("strobe released while wait asserted");
  AST_HOLD0: assert property ($rose(stb_n) && hold_reg == 2'h0 |-> $rose(area_select_n))
    else $error("hold code 00 timing wrong");
  AST_HOLD1: assert property ($rose(stb_n) && hold_reg == 2'h1 |-> !area_select_n ##1 $rose(area_select_n))
    else $error("hold code 01 timing wrong");
  AST_HOLD2: assert property ($rose(stb_n) && hold_reg == 2'h2 |-> (!area_select_n) [*2] ##1 area_select_n)
    else $error("hold code 10 timing wrong");
  AST_STB_IN_SEL: assert property (!stb_n |-> !area_select_n)
    else $error("strobe outside area select");
  AST_RSV_ZERO: assert property (psel && penable && pready && !pwrite && paddr == OFF_TIMING |->
    prdata[TIM_RSV_MSB:TIM_RSV_LSB] == 4'h0)
    else $error("reserved timing bits not zero");
endmodule : csw_ctrl_chk

bind csw_ctrl csw_ctrl_chk csw_ctrl_chk_i (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
  .pready, .area_select_n, .rd_strobe_n, .byte_lane_strobe_n, .ext_wait_n);

// *** dv/csw_mem_model.sv ***
// behavioural external memory with a wait source on the chip-select bus
module csw_mem_model (
  // clock
  input  wire logic                       clk,
  // device pins
  input  wire logic [csw_pkg::EXT_AW-1:0] ext_addr,
  input  wire logic [csw_pkg::EXT_DW-1:0] ext_dout,
  input  wire logic                       ext_dout_oe,
  input  wire logic                       area_select_n,
  input  wire logic                       rd_strobe_n,
  input  wire logic [csw_pkg::LANES-1:0]  byte_lane_strobe_n,
  output logic      [csw_pkg::EXT_DW-1:0] ext_din,
  output logic                            ext_wait_n,
  // bench control
  input  wire logic [7:0]                 wait_len
);
  timeunit 1ns;
  timeprecision 1ps;
  import csw_pkg::*;
  logic [EXT_DW-1:0] mem [16];
  logic [EXT_DW-1:0] last_q;
  int                wcnt;
  initial begin
    ext_wait_n = 1'b1;
    wcnt       = 0;
    last_q     = 16'h0000;
    for (int i = 0; i < 16; i++) mem[i] = 16'h0000;
  end
  // released bus shows the inverse of its last value, never a stale match
  assign ext_din = area_select_n ? ~last_q : mem[ext_addr[3:0]];
  always @(posedge clk) begin
    if (!area_select_n) last_q <= mem[ext_addr[3:0]];
    // store while the strobes are low: with hold 00 the output enable drops at the strobe's rise
    if (!(&byte_lane_strobe_n) && ext_dout_oe) mem[ext_addr[3:0]] <= ext_dout;
    wcnt <= (rd_strobe_n & (&byte_lane_strobe_n)) ? 0 : wcnt + 1;
    // not ready until wait_len strobe cycles pass
    // with a nonzero wait_len, wait stays low between accesses, so a zero-wait strobe already sees it synchronised
    ext_wait_n <= (wcnt >= int'(wait_len));
  end
endmodule : csw_mem_model

// *** dv/tb_chip_select_wait_timing.sv ***
// self-checking bench for the chip-select wait and hold timing block
module tb_chip_select_wait_timing;
  timeunit 1ns;
  timeprecision 1ps;
  import csw_pkg::*;
  typedef struct {logic [3:0] code; logic msk; logic [1:0] hold; logic wr; logic [7:0] wlen;
    logic [3:0] addr; logic [15:0] data; int len;} csw_row_t;
  logic               clk, rst_n, psel, penable, pwrite, pready, pslverr, errv, sel_q;
  logic               ext_dout_oe, area_select_n, rd_strobe_n, ext_wait_n, busy, stb_n;
  logic [PADDR_W-1:0] paddr;
  logic [PDATA_W-1:0] pwdata, prdata, rdv;
  logic [EXT_AW-1:0]  ext_addr;
  logic [EXT_DW-1:0]  ext_dout, ext_din;
  logic [LANES-1:0]   byte_lane_strobe_n;
  logic [7:0]         wait_len;
  int                 n_mismatch, cmp_count, cyc, run, hrun, last_len, last_hold;
  csw_row_t rows [6] = '{
    '{4'h9, 1'b1, 2'h0, 1'b1, 8'd0, 4'h3, 16'h1234, 13},
    '{4'hA, 1'b0, 2'h1, 1'b0, 8'd0, 4'h3, 16'h1234, 15},
    '{4'hB, 1'b1, 2'h2, 1'b1, 8'd0, 4'h5, 16'hABCD, 19},
    '{4'hC, 1'b0, 2'h0, 1'b0, 8'd0, 4'h5, 16'hABCD, 25},
    '{4'h0, 1'b1, 2'h1, 1'b1, 8'd5, 4'h7, 16'h0F0F, 1},
    '{4'h2, 1'b1, 2'h2, 1'b0, 8'd6, 4'h7, 16'h0F0F, 3}};
  csw_ctrl csw_ctrl_i (.clk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .ext_addr, .ext_dout, .ext_dout_oe, .ext_din, .area_select_n, .rd_strobe_n, .byte_lane_strobe_n,
    .ext_wait_n, .busy);
  csw_mem_model csw_mem_model_i (.clk, .ext_addr, .ext_dout, .ext_dout_oe, .area_select_n, .rd_strobe_n,
    .byte_lane_strobe_n, .ext_din, .ext_wait_n, .wait_len);
  assign stb_n = rd_strobe_n & (&byte_lane_strobe_n);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // strobe length and strobe-to-deselect cycles, seen at the pins
  always @(posedge clk) begin
    cyc   <= cyc + 1;
    sel_q <= area_select_n;
    run   <= stb_n ? 0 : run + 1;
    if (stb_n && run != 0) last_len <= run;
    hrun <= stb_n ? hrun + int'(!area_select_n) : 0;
    if (area_select_n && !sel_q) last_hold <= hrun;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rdv     = prdata;
    errv    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk(32'h0, 32'h1, "no pready");
  endtask : apb
  task automatic acc(input csw_row_t r);
    int n;
    n = 0;
    wait_len <= r.wlen;
    // only legal codes, reserved bits written zero
    apb(1'b1, OFF_TIMING, {21'h0, r.code, r.msk, 4'h0, r.hold});
    apb(1'b1, OFF_ADDR, {28'h0, r.addr});
    apb(1'b1, OFF_WDATA, {16'h0, r.data});
    apb(1'b1, OFF_CMD, {30'h0, r.wr, 1'b1});
    do begin
      @(posedge clk);
      n++;
    end while ((busy !== 1'b0 || n < 2) && n < 300);
    if (n >= 300) chk(32'h0, 32'h1, "access never finished");
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rdv[STAT_DONE_BIT], 1'b1, "done flag");
    apb(1'b1, OFF_STATUS, 32'h2);
    if (!r.wr) begin
      apb(1'b0, OFF_RDATA, 32'h0);
      chk(rdv[15:0], r.data, "read data");
    end
  endtask : acc
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, wait_len} = '0;
    {n_mismatch, cmp_count, cyc, run, hrun, last_len, last_hold} = '0;
    sel_q = 1'b1;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFF_TIMING, 32'h0);
    chk(rdv, 32'h0, "timing after reset");
    apb(1'b1, OFF_TIMING, 32'h0000_0642);
    apb(1'b0, OFF_TIMING, 32'h0);
    chk(rdv, 32'h0000_0642, "timing readback");
    for (int i = 0; i < 6; i++) begin
      acc(rows[i]);
      chk(last_len, rows[i].len, "strobe cycles");
      chk(last_hold, rows[i].hold, "hold cycles");
    end
    acc('{4'h0, 1'b0, 2'h0, 1'b1, 8'd6, 4'h8, 16'h5A5A, 0});
    chk(last_len > 6, 1'b1, "zero count not stretched");
    acc('{4'h9, 1'b0, 2'h1, 1'b0, 8'd20, 4'h8, 16'h5A5A, 0});
    chk(last_len > 20, 1'b1, "access not stretched");
    wait_len <= 8'd0;
    apb(1'b0, 8'h20, 32'h0);
    chk(errv, 1'b1, "unmapped access");
    apb(1'b1, OFF_TIMING, 32'h0000_0642);
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, OFF_TIMING, 32'h0);
    chk(rdv, 32'h0, "timing after second reset");
    results();
  end
endmodule : tb_chip_select_wait_timing
